// File: pkg/burst_sram_pkg.sv
// Operation
// - Low write select at K rise starts write
// - Deselected write port ignores write data
// - Masks sampled on both clocks during writes
// - Masked byte is not written, stays unchanged
// - Nine-bit lanes, mask n covers lane n
// - Shared address captured on K rise when active
// - Address 21 bits narrow, 20 bits wide
// - Address ignored when its port is deselected
// - Read words launched on both clock rises
// - Deselected read port floats its outputs
// - Low read select at K rise starts read
// - Finish read, float after next K rise
// - Each read gives four sequential words
// - Read valid edge-aligned with echo clocks
// - Termination range taken from pin at power-up
// - Undriven termination pin selects high range
// - Accesses start only on K rise
// - Complementary clock captures and launches data
// - Write data captured on both clocks, writes only
// - Echo clocks run continuously from K
// - PLL disabled selects single-cycle latency mode
package burst_sram_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int LANE_W = 9;       // Bits per byte lane
  localparam int BEAT_W = 2;       // Beat index width, four beats
  localparam int DATA_W_X18 = 18;  // Narrow variant data width
  localparam int DATA_W_X36 = 36;  // Wide variant data width
  localparam int ADDR_W_X18 = 21;  // Narrow variant address width
  localparam int ADDR_W_X36 = 20;  // Wide variant address width

  // Beat numbers within a burst
  localparam logic [1:0] BEAT_0 = 2'h0;
  localparam logic [1:0] BEAT_1 = 2'h1;
  localparam logic [1:0] BEAT_2 = 2'h2;
  localparam logic [1:0] BEAT_3 = 2'h3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic TERM_HIGH_RESET = 1'h1;  // High range until pin is seen
  localparam logic PLL_ON_RESET = 1'h1;     // Normal latency mode

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [1:0] {W_IDLE, W_HALF, W_TAIL} wr_state_t;
  typedef enum logic [1:0] {R_IDLE, R_WAIT, R_B01, R_B23} rd_state_t;

endpackage

// File: src/burst_sram_port.sv
`timescale 1ns/10ps
`default_nettype none

module burst_sram_port #(
  parameter int DATA_W = burst_sram_pkg::DATA_W_X18,
  parameter int ADDR_W = burst_sram_pkg::ADDR_W_X18,
  parameter int ARRAY_AW = burst_sram_pkg::ADDR_W_X18,
  parameter int LANES = DATA_W / burst_sram_pkg::LANE_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic k_clk,
  input wire logic kn_clk,
  input wire logic write_port_select_n,
  input wire logic read_port_select_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [DATA_W-1:0] write_data,
  input wire logic [LANES-1:0] byte_lane_write_mask_n,
  input wire logic pll_disable_n,
  input wire logic termination_range_pin,
  output logic [DATA_W-1:0] read_data_rise,
  output logic read_data_rise_oe,
  output logic [DATA_W-1:0] read_data_fall,
  output logic read_data_fall_oe,
  output logic read_valid_flag,
  output logic echo_clock,
  output logic echo_clock_n,
  output logic termination_high_range
);

  localparam int IDX_W = ARRAY_AW + burst_sram_pkg::BEAT_W;

  // ****************************************
  // Storage
  // ****************************************
  logic [DATA_W-1:0] mem [0:(2**IDX_W)-1];  // Four words per location

  // Keep enabled lanes of new data, old contents elsewhere
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w,
                                              input logic [DATA_W-1:0] new_w,
                                              input logic [LANES-1:0] mask_n);
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int l = 0; l < LANES; l++) begin
      if (!mask_n[l]) begin
        res[l*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] =
          new_w[l*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W];
      end
    end
    return res;
  endfunction

  // ****************************************
  // Termination range capture (clk domain)
  // ****************************************
  logic term_s1_ff, term_s2_ff, term_s3_ff;  // Pin synchroniser
  logic term_done_ff, nxt_term_done;         // Range already taken
  logic [2:0] term_fill_ff, nxt_term_fill;   // Stages already holding real pin samples
  logic term_high_ff, nxt_term_high;         // Selected range

  // Take the range once, the first time the pin reads stable after reset
  always_comb begin
    nxt_term_done = term_done_ff;
    nxt_term_high = term_high_ff;
    nxt_term_fill = {term_fill_ff[1:0], 1'h1};
    // Reset values in the stages must never be mistaken for the pin
    if (!term_done_ff && term_fill_ff[2] && (term_s2_ff == term_s3_ff)) begin
      nxt_term_high = term_s3_ff;
      nxt_term_done = 1'h1;
    end
  end

  // High range by default; a pad pull-up makes a floating pin read high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      term_s1_ff <= burst_sram_pkg::TERM_HIGH_RESET;
      term_s2_ff <= burst_sram_pkg::TERM_HIGH_RESET;
      term_s3_ff <= burst_sram_pkg::TERM_HIGH_RESET;
      term_done_ff <= 1'h0;
      term_fill_ff <= '0;
      term_high_ff <= burst_sram_pkg::TERM_HIGH_RESET;
    end else begin
      term_s1_ff <= termination_range_pin;
      term_s2_ff <= term_s1_ff;
      term_s3_ff <= term_s2_ff;
      term_done_ff <= nxt_term_done;
      term_fill_ff <= nxt_term_fill;
      term_high_ff <= nxt_term_high;
    end
  end

  // ****************************************
  // Latency mode synchroniser (K domain)
  // ****************************************
  logic mode_s1_ff, mode_s2_ff, mode_s3_ff;  // Pin synchroniser
  logic pll_on_ff, nxt_pll_on;               // 1: extra cycle of latency

  // Mode changes only once both late stages agree
  always_comb begin
    nxt_pll_on = pll_on_ff;
    if (mode_s2_ff == mode_s3_ff) begin
      nxt_pll_on = mode_s3_ff;
    end
  end

  always_ff @(posedge k_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_s1_ff <= burst_sram_pkg::PLL_ON_RESET;
      mode_s2_ff <= burst_sram_pkg::PLL_ON_RESET;
      mode_s3_ff <= burst_sram_pkg::PLL_ON_RESET;
      pll_on_ff <= burst_sram_pkg::PLL_ON_RESET;
    end else begin
      mode_s1_ff <= pll_disable_n;
      mode_s2_ff <= mode_s1_ff;
      mode_s3_ff <= mode_s2_ff;
      pll_on_ff <= nxt_pll_on;
    end
  end

  // ****************************************
  // Write port (K domain)
  // ****************************************
  burst_sram_pkg::wr_state_t wst_ff, nxt_wst;   // Write burst phase
  logic [ARRAY_AW-1:0] waddr_ff, nxt_waddr;     // Captured write address
  logic [DATA_W-1:0] kn_data_ff, nxt_kn_data;   // Odd beat from K-bar edge
  logic [LANES-1:0] kn_mask_ff, nxt_kn_mask;    // Its mask
  logic wa_en, wb_en;                           // Two array write ports
  logic [IDX_W-1:0] wa_idx, wb_idx;
  logic [DATA_W-1:0] wa_data, wb_data;
  logic [LANES-1:0] wa_mask, wb_mask;

  // Port A commits odd beats, port B even beats from the pins
  always_comb begin
    nxt_wst = wst_ff;
    nxt_waddr = waddr_ff;
    wa_en = 1'h0;
    wa_idx = '0;
    wa_data = kn_data_ff;
    wa_mask = kn_mask_ff;
    wb_en = 1'h0;
    wb_idx = {address[ARRAY_AW-1:0], burst_sram_pkg::BEAT_0};
    wb_data = write_data;
    wb_mask = byte_lane_write_mask_n;
    case (wst_ff)
      burst_sram_pkg::W_IDLE: begin
        // Deselected: data, masks and address all ignored
        if (!write_port_select_n) begin
          nxt_waddr = address[ARRAY_AW-1:0];
          wb_en = 1'h1;
          nxt_wst = burst_sram_pkg::W_HALF;
        end
      end
      burst_sram_pkg::W_HALF: begin
        wa_en = 1'h1;
        wa_idx = {waddr_ff, burst_sram_pkg::BEAT_1};
        wb_en = 1'h1;
        wb_idx = {waddr_ff, burst_sram_pkg::BEAT_2};
        nxt_wst = burst_sram_pkg::W_TAIL;
      end
      burst_sram_pkg::W_TAIL: begin
        wa_en = 1'h1;
        wa_idx = {waddr_ff, burst_sram_pkg::BEAT_3};
        // A new write may follow straight on
        if (!write_port_select_n) begin
          nxt_waddr = address[ARRAY_AW-1:0];
          wb_en = 1'h1;
          nxt_wst = burst_sram_pkg::W_HALF;
        end else begin
          nxt_wst = burst_sram_pkg::W_IDLE;
        end
      end
      default: begin
        nxt_wst = burst_sram_pkg::W_IDLE;
      end
    endcase
  end

  always_ff @(posedge k_clk or negedge rst_n) begin
    if (!rst_n) begin
      wst_ff <= burst_sram_pkg::W_IDLE;
      waddr_ff <= '0;
    end else begin
      wst_ff <= nxt_wst;
      waddr_ff <= nxt_waddr;
    end
  end

  // Array writes; the two ports never hit the same word
  always_ff @(posedge k_clk) begin
    if (wa_en) begin
      mem[wa_idx] <= merge(mem[wa_idx], wa_data, wa_mask);
    end
    if (wb_en) begin
      mem[wb_idx] <= merge(mem[wb_idx], wb_data, wb_mask);
    end
  end

  // ****************************************
  // Read port (K domain)
  // ****************************************
  burst_sram_pkg::rd_state_t rst_ff, nxt_rst;   // Read burst phase
  logic [ARRAY_AW-1:0] raddr_ff, nxt_raddr;     // Captured read address
  logic pend_ff, nxt_pend;                      // Next read queued
  logic [DATA_W-1:0] q_rise_ff, nxt_q_rise;     // Even beat on K
  logic [DATA_W-1:0] odd_ff, nxt_odd;           // Odd beat for K-bar
  logic [DATA_W-1:0] hold2_ff, nxt_hold2;       // Prefetched beat 2
  logic [DATA_W-1:0] hold3_ff, nxt_hold3;       // Prefetched beat 3
  logic oe_rise_ff, nxt_oe_rise;                // Even-beat drive enable
  logic valid_ff, nxt_valid;                    // Read valid
  logic echo_ff;                                // K-side echo toggle
  logic rd_take;                                // Read select accepted
  burst_sram_pkg::rd_state_t rd_first;          // Phase after a request

  // Prefetching beats 2 and 3 frees the address for a queued read
  always_comb begin
    nxt_rst = rst_ff;
    nxt_raddr = raddr_ff;
    nxt_pend = pend_ff;
    nxt_q_rise = '0;
    nxt_odd = odd_ff;
    nxt_hold2 = hold2_ff;
    nxt_hold3 = hold3_ff;
    nxt_oe_rise = 1'h0;
    nxt_valid = 1'h0;
    rd_first = pll_on_ff ? burst_sram_pkg::R_WAIT : burst_sram_pkg::R_B01;
    rd_take = !read_port_select_n && (rst_ff != burst_sram_pkg::R_WAIT) &&
              !((rst_ff == burst_sram_pkg::R_B23) && pend_ff);
    if (rd_take) begin
      nxt_raddr = address[ARRAY_AW-1:0];
    end
    case (rst_ff)
      burst_sram_pkg::R_IDLE: begin
        if (rd_take) begin
          nxt_rst = rd_first;
        end
      end
      burst_sram_pkg::R_WAIT: begin
        nxt_rst = burst_sram_pkg::R_B01;
      end
      burst_sram_pkg::R_B01: begin
        nxt_q_rise = mem[{raddr_ff, burst_sram_pkg::BEAT_0}];
        nxt_odd = mem[{raddr_ff, burst_sram_pkg::BEAT_1}];
        nxt_hold2 = mem[{raddr_ff, burst_sram_pkg::BEAT_2}];
        nxt_hold3 = mem[{raddr_ff, burst_sram_pkg::BEAT_3}];
        nxt_oe_rise = 1'h1;
        nxt_valid = 1'h1;
        nxt_pend = rd_take;
        nxt_rst = burst_sram_pkg::R_B23;
      end
      burst_sram_pkg::R_B23: begin
        // In-flight burst always completes before the float
        nxt_q_rise = hold2_ff;
        nxt_odd = hold3_ff;
        nxt_oe_rise = 1'h1;
        nxt_valid = 1'h1;
        nxt_pend = 1'h0;
        nxt_rst = (pend_ff || rd_take) ? rd_first : burst_sram_pkg::R_IDLE;
      end
      default: begin
        nxt_rst = burst_sram_pkg::R_IDLE;
      end
    endcase
  end

  always_ff @(posedge k_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_ff <= burst_sram_pkg::R_IDLE;
      raddr_ff <= '0;
      pend_ff <= 1'h0;
      q_rise_ff <= '0;
      odd_ff <= '0;
      hold2_ff <= '0;
      hold3_ff <= '0;
      oe_rise_ff <= 1'h0;
      valid_ff <= 1'h0;
      echo_ff <= 1'h0;
    end else begin
      rst_ff <= nxt_rst;
      raddr_ff <= nxt_raddr;
      pend_ff <= nxt_pend;
      q_rise_ff <= nxt_q_rise;
      odd_ff <= nxt_odd;
      hold2_ff <= nxt_hold2;
      hold3_ff <= nxt_hold3;
      oe_rise_ff <= nxt_oe_rise;
      valid_ff <= nxt_valid;
      echo_ff <= ~echo_ff;
    end
  end

  // ****************************************
  // Complementary clock side (K-bar domain)
  // ****************************************
  logic [DATA_W-1:0] q_fall_ff, nxt_q_fall;  // Odd beat on K-bar
  logic oe_fall_ff, nxt_oe_fall;             // Odd-beat drive enable
  logic echo_n_ff;                           // K-bar echo toggle

  // K-bar is the inverse of K, so K-side flops are read directly here
  always_comb begin
    nxt_kn_data = kn_data_ff;
    nxt_kn_mask = kn_mask_ff;
    if (wst_ff != burst_sram_pkg::W_IDLE) begin
      nxt_kn_data = write_data;
      nxt_kn_mask = byte_lane_write_mask_n;
    end
    nxt_q_fall = oe_rise_ff ? odd_ff : '0;
    nxt_oe_fall = oe_rise_ff;
  end

  always_ff @(posedge kn_clk or negedge rst_n) begin
    if (!rst_n) begin
      kn_data_ff <= '0;
      kn_mask_ff <= '1;
      q_fall_ff <= '0;
      oe_fall_ff <= 1'h0;
      echo_n_ff <= 1'h0;
    end else begin
      kn_data_ff <= nxt_kn_data;
      kn_mask_ff <= nxt_kn_mask;
      q_fall_ff <= nxt_q_fall;
      oe_fall_ff <= nxt_oe_fall;
      echo_n_ff <= ~echo_n_ff;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign read_data_rise = q_rise_ff;
  assign read_data_rise_oe = oe_rise_ff;
  assign read_data_fall = q_fall_ff;
  assign read_data_fall_oe = oe_fall_ff;
  assign read_valid_flag = valid_ff;
  assign echo_clock = echo_ff;
  assign echo_clock_n = echo_n_ff;
  assign termination_high_range = term_high_ff;

endmodule

`default_nettype wire

// File: verification/burst_sram_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Memory controller model
// ****
module burst_sram_ctrl_model #(
  parameter int DW = 18,
  parameter int AW = 21,
  parameter int LN = 2
) (
  output logic k_clk,
  output logic kn_clk,
  output logic write_port_select_n,
  output logic read_port_select_n,
  output logic [AW-1:0] address,
  output logic [DW-1:0] write_data,
  output logic [LN-1:0] byte_lane_write_mask_n,
  input wire logic [DW-1:0] read_data_rise,
  input wire logic [DW-1:0] read_data_fall,
  input wire logic read_data_rise_oe,
  input wire logic read_valid_flag
);
  // Free-running K pair, phase offset from the core clock
  initial begin
    k_clk = 1'b0;
    kn_clk = 1'b1;
    write_port_select_n = 1'b1;
    read_port_select_n = 1'b1;
    address = '0;
    write_data = '0;
    byte_lane_write_mask_n = '1;
    #13;
    forever begin
      #40 k_clk = ~k_clk;
      kn_clk = ~kn_clk;
    end
  end
  // Each beat is driven one edge ahead of its capture edge
  task automatic wr(input logic en, input logic [AW-1:0] a,
                    input logic [DW-1:0] d [4], input logic [LN-1:0] m [4]);
    for (int b = 0; b < 4; b++) begin
      if (b % 2 == 0) @(posedge kn_clk);
      else @(posedge k_clk);
      write_port_select_n <= (b == 0) ? ~en : 1'b1;
      address <= (b == 0) ? a : ~a; // Junk once released
      write_data <= d[b];
      byte_lane_write_mask_n <= m[b];
    end
    @(posedge kn_clk);
    write_data <= ~d[3]; // Released bus shows junk
    byte_lane_write_mask_n <= ~m[3];
  endtask
  // One burst, words sampled mid-beat, drive state one beat after
  task automatic rd(input int lat, input logic [AW-1:0] a,
                    output logic [DW-1:0] q [4], output logic vld, output logic fl);
    @(posedge kn_clk);
    read_port_select_n <= 1'b0;
    address <= a;
    @(posedge k_clk);
    read_port_select_n <= 1'b1;
    address <= ~a;
    for (int b = 0; b < 5; b++) begin
      if (b == 0) repeat (lat) @(posedge k_clk);
      else if (b % 2) @(posedge kn_clk);
      else @(posedge k_clk);
      #20;
      if (b < 4) q[b] = (b % 2) ? read_data_fall : read_data_rise;
      if (b == 0) vld = read_valid_flag;
    end
    fl = read_data_rise_oe;
  endtask
endmodule
`default_nettype wire

// File: verification/burst_sram_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Port checker
// ****
module burst_sram_properties #(
  parameter int DATA_W = 18
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic k_clk,
  input wire logic kn_clk,
  input wire logic read_port_select_n,
  input wire logic pll_disable_n,
  input wire logic [DATA_W-1:0] read_data_rise,
  input wire logic read_data_rise_oe,
  input wire logic [DATA_W-1:0] read_data_fall,
  input wire logic read_data_fall_oe,
  input wire logic read_valid_flag,
  input wire logic echo_clock,
  input wire logic echo_clock_n,
  input wire logic termination_high_range
);
  logic [2:0] idle_ff, nxt_idle; // Quiet read cycles
  logic [2:0] mode_ff, nxt_mode; // K edges since mode pin moved
  logic pll_ff, nxt_pll; // Mode pin at last K edge
  logic [3:0] tcnt_ff, nxt_tcnt; // Core edges since reset
  // Saturating, so long runs never wrap
  always_comb begin
    nxt_idle = (read_port_select_n && !read_valid_flag) ? idle_ff + 3'(idle_ff != 3'h7) : 3'h0;
    nxt_pll = pll_disable_n;
    nxt_mode = (pll_disable_n != pll_ff) ? 3'h0 : mode_ff + 3'(mode_ff != 3'h7);
    nxt_tcnt = tcnt_ff + 4'(tcnt_ff != 4'hF);
  end
  // Link side helpers
  always_ff @(posedge k_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_ff <= 3'h0;
      mode_ff <= 3'h0;
      pll_ff <= 1'h1;
    end else begin
      idle_ff <= nxt_idle;
      mode_ff <= nxt_mode;
      pll_ff <= nxt_pll;
    end
  end
  // Core side helper
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tcnt_ff <= 4'h0;
    else tcnt_ff <= nxt_tcnt;
  end
  // A request only after a quiet spell, so no queueing muddles latency
  sequence s_rd_req;
    !read_port_select_n && idle_ff >= 3'h3;
  endsequence
  sequence s_burst;
    read_valid_flag [*2];
  endsequence
  a_read_short: assert property (@(posedge k_clk) disable iff (!rst_n)
    s_rd_req ##0 (mode_ff == 3'h7 && !pll_ff) |-> ##2 s_burst) else $error("short burst late");
  a_read_normal: assert property (@(posedge k_clk) disable iff (!rst_n)
    s_rd_req ##0 (mode_ff == 3'h7 && pll_ff) |-> ##2 !read_valid_flag ##1 s_burst)
    else $error("normal burst misplaced");
  a_valid_oe: assert property (@(posedge k_clk) disable iff (!rst_n)
    read_valid_flag == read_data_rise_oe) else $error("valid and drive differ");
  a_echo_toggle: assert property (@(posedge k_clk) disable iff (!rst_n)
    $past(rst_n) |-> echo_clock != $past(echo_clock)) else $error("echo stalled");
  a_echo_n_toggle: assert property (@(posedge kn_clk) disable iff (!rst_n)
    $past(rst_n) |-> echo_clock_n != $past(echo_clock_n)) else $error("echo n stalled");
  a_fall_follows: assert property (@(posedge kn_clk) disable iff (!rst_n)
    $past(rst_n) |-> read_data_fall_oe == $past(read_data_rise_oe)) else $error("fall drive off");
  a_rise_float: assert property (@(posedge k_clk) disable iff (!rst_n)
    !read_data_rise_oe |-> read_data_rise == '0) else $error("rise data not released");
  a_fall_float: assert property (@(posedge kn_clk) disable iff (!rst_n)
    !read_data_fall_oe |-> read_data_fall == '0) else $error("fall data not released");
  a_term_default: assert property (@(posedge clk) disable iff (!rst_n)
    tcnt_ff < 4'h2 |-> termination_high_range) else $error("range not high at start");
  a_term_frozen: assert property (@(posedge clk) disable iff (!rst_n)
    tcnt_ff >= 4'h8 |-> $stable(termination_high_range)) else $error("range moved");
endmodule
bind burst_sram_port burst_sram_properties #(.DATA_W(DATA_W)) i_props (
  .clk(clk), .rst_n(rst_n), .k_clk(k_clk), .kn_clk(kn_clk),
  .read_port_select_n(read_port_select_n), .pll_disable_n(pll_disable_n),
  .read_data_rise(read_data_rise), .read_data_rise_oe(read_data_rise_oe),
  .read_data_fall(read_data_fall), .read_data_fall_oe(read_data_fall_oe),
  .read_valid_flag(read_valid_flag), .echo_clock(echo_clock),
  .echo_clock_n(echo_clock_n), .termination_high_range(termination_high_range));
`default_nettype wire

// File: verification/test_quad_rate_sram_port.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module test_quad_rate_sram_port;
  localparam int DW = 18;
  localparam int AW = 21;
  localparam int LN = 2;
  localparam int RW = 6; // Shrunk array rows
  localparam int LW = burst_sram_pkg::LANE_W;
  logic clk, rst_n, pll_disable_n, termination_range_pin, k_clk, kn_clk;
  logic write_port_select_n, read_port_select_n, read_valid_flag;
  logic read_data_rise_oe, read_data_fall_oe, echo_clock, echo_clock_n;
  logic termination_high_range;
  logic [AW-1:0] address;
  logic [DW-1:0] write_data, read_data_rise, read_data_fall;
  logic [LN-1:0] byte_lane_write_mask_n;
  logic [DW-1:0] mem [256]; // Reference words by row and beat
  logic [AW-1:0] ad [4];
  logic [DW-1:0] d [4], q [4];
  logic [LN-1:0] m [4];
  logic vld, fl;
  int mismatches = 0;
  int n_checks = 0;
  int seed;
  burst_sram_port #(.DATA_W(DW), .ADDR_W(AW), .ARRAY_AW(RW)) i_dut (
    .clk(clk), .rst_n(rst_n), .k_clk(k_clk), .kn_clk(kn_clk),
    .write_port_select_n(write_port_select_n), .read_port_select_n(read_port_select_n),
    .address(address), .write_data(write_data), .byte_lane_write_mask_n(byte_lane_write_mask_n),
    .pll_disable_n(pll_disable_n), .termination_range_pin(termination_range_pin),
    .read_data_rise(read_data_rise), .read_data_rise_oe(read_data_rise_oe),
    .read_data_fall(read_data_fall), .read_data_fall_oe(read_data_fall_oe),
    .read_valid_flag(read_valid_flag), .echo_clock(echo_clock), .echo_clock_n(echo_clock_n),
    .termination_high_range(termination_high_range));
  burst_sram_ctrl_model #(.DW(DW), .AW(AW), .LN(LN)) i_ctrl (
    .k_clk(k_clk), .kn_clk(kn_clk), .write_port_select_n(write_port_select_n),
    .read_port_select_n(read_port_select_n), .address(address), .write_data(write_data),
    .byte_lane_write_mask_n(byte_lane_write_mask_n), .read_data_rise(read_data_rise),
    .read_data_fall(read_data_fall), .read_data_rise_oe(read_data_rise_oe),
    .read_valid_flag(read_valid_flag));
  // Expected word: only lanes with mask low take new data
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, input logic [DW-1:0] n,
                                          input logic [LN-1:0] mk);
    logic [DW-1:0] r;
    r = o;
    for (int l = 0; l < LN; l++) begin
      if (!mk[l]) r[l*LW +: LW] = n[l*LW +: LW];
    end
    return r;
  endfunction
  // Write burst; the reference follows only a selected write
  task automatic do_wr(input logic en, input int i, input logic masked);
    for (int b = 0; b < 4; b++) begin
      d[b] = DW'($urandom());
      m[b] = masked ? LN'($urandom()) : '0;
      if (en) mem[{ad[i][RW-1:0], 2'(b)}] = merge(mem[{ad[i][RW-1:0], 2'(b)}], d[b], m[b]);
    end
    i_ctrl.wr(en, ad[i], d, m);
  endtask
  // Read burst and compare all four words
  task automatic do_rd(input int lat, input int i);
    i_ctrl.rd(lat, ad[i], q, vld, fl);
    `CHK(vld, 1'b1)
    for (int b = 0; b < 4; b++) `CHK(q[b], mem[{ad[i][RW-1:0], 2'(b)}])
    `CHK(fl, 1'b0)
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Watchdog, far beyond the expected run of some 11 us
  initial begin
    #400000;
    mismatches++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    pll_disable_n = 1'b1;
    termination_range_pin = 1'b0;
    seed = $urandom(32'h410B50CD);
    for (int i = 0; i < 4; i++) ad[i] = AW'({$urandom(), RW'(i * 21)}); // Rows 0 to top
    repeat (12) @(posedge clk);
    @(negedge clk);
    `CHK(termination_high_range, 1'b1)
    `CHK(read_data_rise_oe, 1'b0)
    @(posedge clk) rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    `CHK(termination_high_range, 1'b0)
    @(posedge clk) termination_range_pin <= 1'b1;
    for (int i = 0; i < 4; i++) do_wr(1'b1, i, 1'b0);
    for (int i = 0; i < 4; i++) do_rd(2, i);
    // Masked writes, then ghost writes that must leave no trace
    for (int i = 0; i < 4; i++) begin
      do_wr(1'b1, i, 1'b1);
      do_wr(1'b0, i, 1'b0);
      do_rd(2, i);
    end
    @(posedge clk) pll_disable_n <= 1'b0;
    repeat (20) @(posedge clk);
    for (int i = 0; i < 4; i++) do_rd(1, i);
    `CHK(termination_high_range, 1'b0)
    // Second reset: range retaken, array kept
    @(posedge clk) rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    @(negedge clk);
    `CHK(termination_high_range, 1'b1)
    do_rd(1, 3);
    conclude();
  end
endmodule
`default_nettype wire
